// file: verilog/ch2_diag_consts.svh
// Offsets, field positions, reset values and timing figures of channel 2 regs
// How it works
// - 4-bit overcurrent code, 10 A to 70 A, resets 8
// - Bit 15 set disables voltage sensing, reset 1
// - Bit 14 set disables temperature sensing, reset 1
// - Bit 13 set disables current sensing, reset 0
// - Bits 12-11 open-load threshold, storage only
// - Bit 10 selects unity or eightfold current gain
// - Bit 9 selects accurate on-state open-load mode
// - Bits 8-7 blanking 0.4, 1, 2, 4 ms
// - Bits 6-5 pull-up 32 to 256 microamps
// - Bit 4 off-state open-load check, blocked on/fault
// - Bit 3 supply-short check, blocked on/fault
// - Bit 2: 0 auto retry, 1 latch off
// - Bits 1-0 slew code, reset 2
// - Current result: value 9-0, fresh flag 10
// - Temperature result: value 9-0, fresh flag 10
// - Fresh flag set on conversion, cleared by read
// - Inrush window code 0-7, 0 to 100 ms
`ifndef CH2_DIAG_CONSTS_SVH
`define CH2_DIAG_CONSTS_SVH

// ------------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------------
`define OFS_CH2_LIMIT     8'h17
`define OFS_CH2_DIAG      8'h18
`define OFS_CH2_CURRENT   8'h19
`define OFS_CH2_TEMP      8'h1A

// ------------------------------------------------------------------
// Reset values and field positions
// ------------------------------------------------------------------
`define RST_CH2_DIAG      16'hC002
`define RST_CH2_LIMIT     16'h0088
`define RST_OC_CODE       4'h8
`define OC_CODE_MAX       4'hC
`define BIT_VSNS_OFF      15
`define BIT_TSNS_OFF      14
`define BIT_ISNS_OFF      13
`define BIT_GAIN          10
`define BIT_ON_OL         9
`define BIT_OFF_OL        4
`define BIT_SHORT_CHK     3
`define BIT_LATCH         2
`define BIT_FRESH         10

// ------------------------------------------------------------------
// Timing: figures in microseconds, clock in MHz
// ------------------------------------------------------------------
`define CLK_MHZ           20
`define BLANK0_US         400
`define BLANK1_US         1000
`define BLANK2_US         2000
`define BLANK3_US         4000
`define INRUSH_UNIT_US    1000

`endif

// file: verilog/ch2_diag_pkg.sv
// Types shared by the channel 2 diagnostic register bank
package ch2_diag_pkg;

	// Diagnostic configuration fields in register order
	typedef struct packed {
		logic       voltage_sense_off;
		logic       temperature_sense_off;
		logic       current_sense_off;
		logic [1:0] on_open_load_threshold;
		logic       current_gain_select;
		logic       on_open_load_check;
		logic [1:0] fault_blanking_code;
		logic [1:0] pullup_strength_code;
		logic       off_open_load_check;
		logic       supply_short_check;
		logic       fault_latch_select;
		logic [1:0] slew_code;
	} diag_cfg_s;

	// One converter result as seen by the bank
	typedef struct packed {
		logic       valid;
		logic [9:0] value;
	} conv_s;

	// Retry sequencer after a fault shutdown
	typedef enum logic [1:0] {
		CH_RUN     = 2'b00,
		CH_WAIT    = 2'b01,
		CH_LATCHED = 2'b10
	} chan_state_e;

endpackage : ch2_diag_pkg

// file: verilog/ch2_diag_sense_regs.sv
// Channel 2 diagnostic, limit and converter result register bank
`timescale 1ns/1ns
`include "ch2_diag_consts.svh"

module channel2_diag_sense_regs
	import ch2_diag_pkg::*;
#(
	parameter int RETRY_US   = 10000,
	parameter int INRUSH_MAX = 100
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	// Register port from the serial front end
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [15:0] reg_wdata_i,
	output logic      [15:0] reg_rdata_o,
	// Channel status from the power stage
	input  wire logic        ch_on_i,
	input  wire logic        ch_fault_i,
	input  wire logic        fault_shutdown_i,
	input  wire logic        thermal_ok_i,
	input  wire logic        switch_state_register_wr_i,
	// Raw fault detectors awaiting blanking
	input  wire logic        open_load_raw_i,
	input  wire logic        supply_short_raw_i,
	// Converter results
	input  wire conv_s       cur_conv_i,
	input  wire conv_s       temp_conv_i,
	// Controls to analog side
	output diag_cfg_s        diag_cfg_o,
	output logic      [3:0]  ch2_steady_overcurrent_code_o,
	output logic             steady_limit_active_o,
	output logic             retry_allow_o,
	output logic             open_load_fault_o,
	output logic             supply_short_fault_o,
	output logic             cur_conv_en_o,
	output logic             temp_conv_en_o,
	output logic             volt_conv_en_o
);

	// ------------------------------------------------------------------
	// Timing counts
	// ------------------------------------------------------------------
	localparam int BLANK0_CYC = `BLANK0_US * `CLK_MHZ;
	localparam int BLANK1_CYC = `BLANK1_US * `CLK_MHZ;
	localparam int BLANK2_CYC = `BLANK2_US * `CLK_MHZ;
	localparam int BLANK3_CYC = `BLANK3_US * `CLK_MHZ;
	localparam int MS_CYC     = `INRUSH_UNIT_US * `CLK_MHZ;
	localparam int RETRY_CYC  = RETRY_US * `CLK_MHZ;

	// ------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------
	logic [15:0] diag_reg;
	logic [15:0] limit_reg;
	logic [9:0]  cur_value_reg;
	logic        cur_fresh_reg;
	logic [9:0]  temp_value_reg;
	logic        temp_fresh_reg;
	logic [16:0] ol_cnt_reg;
	logic [16:0] ss_cnt_reg;
	logic [16:0] ms_cnt_reg;
	logic [6:0]  inrush_ms_reg;
	logic [31:0] retry_cnt_reg;
	logic        ch_on_d_reg;
	chan_state_e state_reg;

	logic        cur_rd;
	logic        temp_rd;
	logic [16:0] blank_cyc;
	logic [6:0]  inrush_lim;

	// Blanking code to cycle count
	function automatic logic [16:0] blank_count(input logic [1:0] code);
		case (code)
			2'h0: blank_count = 17'(BLANK0_CYC);
			2'h1: blank_count = 17'(BLANK1_CYC);
			2'h2: blank_count = 17'(BLANK2_CYC);
			default: blank_count = 17'(BLANK3_CYC);
		endcase
	endfunction : blank_count

	// Inrush window code to whole milliseconds
	function automatic logic [6:0] inrush_ms(input logic [2:0] code);
		case (code)
			3'h0: inrush_ms = 7'h00;
			3'h1: inrush_ms = 7'h02;
			3'h2: inrush_ms = 7'h04;
			3'h3: inrush_ms = 7'h06;
			3'h4: inrush_ms = 7'h0A;
			3'h5: inrush_ms = 7'h14;
			3'h6: inrush_ms = 7'h32;
			default: inrush_ms = 7'(INRUSH_MAX);
		endcase
	endfunction : inrush_ms

	assign cur_rd  = reg_rd_i && (reg_addr_i == `OFS_CH2_CURRENT);
	assign temp_rd = reg_rd_i && (reg_addr_i == `OFS_CH2_TEMP);
	assign blank_cyc  = blank_count(diag_reg[8:7]);
	assign inrush_lim = inrush_ms(limit_reg[10:8]);

	// ------------------------------------------------------------------
	// Configuration writes
	// ------------------------------------------------------------------
	// Off-state checks may only be armed while off and fault free
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			diag_reg <= `RST_CH2_DIAG;
		end else if (reg_wr_i && reg_addr_i == `OFS_CH2_DIAG) begin
			diag_reg <= reg_wdata_i;
			if (ch_on_i || ch_fault_i) begin
				diag_reg[`BIT_OFF_OL]    <= 1'b0;
				diag_reg[`BIT_SHORT_CHK] <= 1'b0;
			end
			// On-state accuracy mode refused while faulted
			if (ch_fault_i)
				diag_reg[`BIT_ON_OL] <= 1'b0;
		end else if (ch_on_i || ch_fault_i) begin
			diag_reg[`BIT_OFF_OL]    <= 1'b0;
			diag_reg[`BIT_SHORT_CHK] <= 1'b0;
		end
	end

	// Limit register; unsupported codes are stored as written
	always_ff @(posedge clk_i) begin
		if (!rst_b_i)
			limit_reg <= `RST_CH2_LIMIT;
		else if (reg_wr_i && reg_addr_i == `OFS_CH2_LIMIT)
			limit_reg <= reg_wdata_i;
	end

	// ------------------------------------------------------------------
	// Converter results and fresh flags
	// ------------------------------------------------------------------
	// A new conversion in the read cycle keeps the flag set
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			cur_value_reg <= 10'h000;
			cur_fresh_reg <= 1'b0;
		end else if (cur_conv_i.valid && !diag_reg[`BIT_ISNS_OFF]) begin
			cur_value_reg <= cur_conv_i.value;
			cur_fresh_reg <= 1'b1;
		end else if (cur_rd) begin
			cur_fresh_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			temp_value_reg <= 10'h000;
			temp_fresh_reg <= 1'b0;
		end else if (temp_conv_i.valid && !diag_reg[`BIT_TSNS_OFF]) begin
			temp_value_reg <= temp_conv_i.value;
			temp_fresh_reg <= 1'b1;
		end else if (temp_rd) begin
			temp_fresh_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Read data, registered
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_b_i)
			reg_rdata_o <= 16'h0000;
		else if (reg_rd_i) begin
			if (reg_addr_i == `OFS_CH2_DIAG)
				reg_rdata_o <= diag_reg;
			else if (reg_addr_i == `OFS_CH2_LIMIT)
				reg_rdata_o <= limit_reg;
			else if (cur_rd)
				reg_rdata_o <= {5'h00, cur_fresh_reg, cur_value_reg};
			else if (temp_rd)
				reg_rdata_o <= {5'h00, temp_fresh_reg, temp_value_reg};
			else
				reg_rdata_o <= 16'h0000;
		end
	end

	// ------------------------------------------------------------------
	// Fault blanking timers
	// ------------------------------------------------------------------
	// A fault must persist for the whole blanking time to register
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			ol_cnt_reg        <= 17'h00000;
			open_load_fault_o <= 1'b0;
		end else if (!open_load_raw_i) begin
			ol_cnt_reg        <= 17'h00000;
			open_load_fault_o <= 1'b0;
		end else if (ol_cnt_reg + 17'h00001 >= blank_cyc) begin
			open_load_fault_o <= 1'b1;
		end else begin
			ol_cnt_reg <= ol_cnt_reg + 17'h00001;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			ss_cnt_reg           <= 17'h00000;
			supply_short_fault_o <= 1'b0;
		end else if (!supply_short_raw_i) begin
			ss_cnt_reg           <= 17'h00000;
			supply_short_fault_o <= 1'b0;
		end else if (ss_cnt_reg + 17'h00001 >= blank_cyc) begin
			supply_short_fault_o <= 1'b1;
		end else begin
			ss_cnt_reg <= ss_cnt_reg + 17'h00001;
		end
	end

	// ------------------------------------------------------------------
	// Inrush window: steady limit takes over when it ends
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			ch_on_d_reg   <= 1'b0;
			ms_cnt_reg    <= 17'h00000;
			inrush_ms_reg <= 7'h00;
		end else begin
			ch_on_d_reg <= ch_on_i;
			if (!ch_on_i || !ch_on_d_reg) begin
				ms_cnt_reg    <= 17'h00000;
				inrush_ms_reg <= 7'h00;
			end else if (inrush_ms_reg < inrush_lim) begin
				if (ms_cnt_reg == 17'(MS_CYC - 1)) begin
					ms_cnt_reg    <= 17'h00000;
					inrush_ms_reg <= inrush_ms_reg + 7'h01;
				end else
					ms_cnt_reg <= ms_cnt_reg + 17'h00001;
			end
		end
	end

	// ------------------------------------------------------------------
	// Retry or latch after fault shutdown
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			state_reg     <= CH_RUN;
			retry_cnt_reg <= 32'h00000000;
		end else begin
			case (state_reg)
				CH_RUN: begin
					retry_cnt_reg <= 32'h00000000;
					if (fault_shutdown_i)
						state_reg <= diag_reg[`BIT_LATCH] ? CH_LATCHED
							: CH_WAIT;
				end
				CH_WAIT: begin
					if (retry_cnt_reg < 32'(RETRY_CYC))
						retry_cnt_reg <= retry_cnt_reg + 32'h00000001;
					else if (thermal_ok_i)
						state_reg <= CH_RUN;
				end
				CH_LATCHED: begin
					if (switch_state_register_wr_i)
						state_reg <= CH_RUN;
				end
				default: state_reg <= CH_RUN;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Outputs to the analog side
	// ------------------------------------------------------------------
	assign diag_cfg_o     = diag_cfg_s'(diag_reg);
	assign ch2_steady_overcurrent_code_o = limit_reg[3:0];
	assign steady_limit_active_o = ch_on_d_reg && ch_on_i
		&& (inrush_ms_reg >= inrush_lim);
	assign retry_allow_o  = (state_reg == CH_RUN);
	assign cur_conv_en_o  = !diag_reg[`BIT_ISNS_OFF];
	assign temp_conv_en_o = !diag_reg[`BIT_TSNS_OFF];
	assign volt_conv_en_o = !diag_reg[`BIT_VSNS_OFF];

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	a_fresh_on_conv: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		cur_conv_i.valid && !diag_reg[`BIT_ISNS_OFF] |=> cur_fresh_reg)
		else $error("current fresh flag not set");
	a_fresh_read_clr: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		temp_rd && !temp_conv_i.valid |=> !temp_fresh_reg)
		else $error("temperature fresh flag not cleared");
	a_check_blocked: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		ch_on_i |=> !diag_reg[`BIT_OFF_OL] && !diag_reg[`BIT_SHORT_CHK])
		else $error("off-state check armed while on");
	a_latch_holds: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		state_reg == CH_LATCHED && !switch_state_register_wr_i |=> !retry_allow_o)
		else $error("latched channel released");
	a_reserved_zero: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		cur_rd |=> reg_rdata_o[15:11] == 5'h00)
		else $error("reserved result bits not zero");
	// Enable must follow the written disable bit, not just mirror the reg
	a_sense_enable: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		reg_wr_i && reg_addr_i == `OFS_CH2_DIAG
		|=> volt_conv_en_o == !$past(reg_wdata_i[`BIT_VSNS_OFF]))
		else $error("voltage sense enable mismatch");
	a_reset_defaults: assert property (@(posedge clk_i)
		!rst_b_i |=> diag_reg == 16'hC002 && limit_reg[3:0] == 4'h8)
		else $error("reset defaults wrong");
	a_blank_min: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		$rose(open_load_raw_i) |=> !open_load_fault_o [*8])
		else $error("open load registered before blanking");

	// Fault shutdown while running, split by the latch choice
	sequence s_shut_retry;
		fault_shutdown_i && retry_allow_o && !diag_reg[`BIT_LATCH];
	endsequence
	sequence s_shut_latch;
		fault_shutdown_i && retry_allow_o && diag_reg[`BIT_LATCH];
	endsequence
	sequence s_held_off;
		!retry_allow_o;
	endsequence

	// Even a zero retry time must hold the channel off for one cycle
	a_retry_waits: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		s_shut_retry |=> s_held_off)
		else $error("auto retry skipped the wait");
	a_latch_enter: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		s_shut_latch |=> state_reg == CH_LATCHED)
		else $error("latch mode did not latch");

	// Limit writes reach the threshold output one cycle later
	a_limit_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		reg_wr_i && reg_addr_i == `OFS_CH2_LIMIT
		|=> ch2_steady_overcurrent_code_o == $past(reg_wdata_i[3:0]))
		else $error("threshold code not taken from write");
	a_acc_refused: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		reg_wr_i && reg_addr_i == `OFS_CH2_DIAG && ch_fault_i
		|=> !diag_cfg_o.on_open_load_check)
		else $error("accurate open load armed during fault");
	a_short_blocked: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		ch_fault_i |=> !diag_reg[`BIT_SHORT_CHK] && !diag_reg[`BIT_OFF_OL])
		else $error("off-state check armed during fault");
	a_gain_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		reg_wr_i && reg_addr_i == `OFS_CH2_DIAG
		|=> diag_cfg_o.current_gain_select == $past(reg_wdata_i[`BIT_GAIN]))
		else $error("gain select not taken from write");

	// Read data is the register as it stood at the taking edge
	a_read_latency: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		reg_rd_i && reg_addr_i == `OFS_CH2_DIAG
		|=> reg_rdata_o == $past(diag_reg))
		else $error("diag read data wrong");
	a_temp_fresh: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		temp_conv_i.valid && !diag_reg[`BIT_TSNS_OFF] |=> temp_fresh_reg)
		else $error("temperature fresh flag not set");
	a_cur_read_clr: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		cur_rd && !cur_conv_i.valid |=> !cur_fresh_reg)
		else $error("current fresh flag not cleared");

endmodule : channel2_diag_sense_regs

// file: testbench/reg_host_model.sv
// Register host model that issues single-word accesses to the bank
`timescale 1ns/1ns

module reg_host_model (
	// Clock
	input  wire logic        clk_i,
	// Register port toward the bank
	output logic             reg_wr_o,
	output logic             reg_rd_o,
	output logic      [7:0]  reg_addr_o,
	output logic      [15:0] reg_wdata_o,
	input  wire logic [15:0] reg_rdata_i
);
	// Idle port at time zero
	initial begin
		reg_wr_o    = 1'b0;
		reg_rd_o    = 1'b0;
		reg_addr_o  = 8'h00;
		reg_wdata_o = 16'h0000;
	end

	// One write strobe, then scramble the released lines
	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		logic [15:0] v;
		v = d;
		// Unsupported threshold codes are never sent
		if (a == 8'h17 && v[3:0] > 4'hC) v[3:0] = 4'hC;
		@(posedge clk_i);
		#1;
		reg_wr_o    = 1'b1;
		reg_addr_o  = a;
		reg_wdata_o = v;
		@(posedge clk_i);
		#1;
		reg_wr_o    = 1'b0;
		reg_addr_o  = ~a;
		reg_wdata_o = ~v;
	endtask : wr_reg

	// One read strobe; data is registered at the taking edge
	task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk_i);
		#1;
		reg_rd_o   = 1'b1;
		reg_addr_o = a;
		@(posedge clk_i);
		#1;
		reg_rd_o   = 1'b0;
		reg_addr_o = ~a;
		d          = reg_rdata_i;
	endtask : rd_reg
endmodule : reg_host_model

// file: testbench/tb_channel2_diag_sense_regs.sv
// Self-checking bench for the channel 2 diagnostic register bank
`timescale 1ns/1ns

`define CHK(n, e, g) check(n, e, g)

module tb_channel2_diag_sense_regs;
	import ch2_diag_pkg::*;

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic        clk_i, rst_b_i, wr, rd;
	logic [7:0]  addr;
	logic [15:0] wdata, rdata;
	logic        ch_on, ch_fault, shut, therm_ok, sw_wr, ol_raw, ss_raw;
	conv_s       cur_conv, temp_conv;
	diag_cfg_s   cfg;
	logic [3:0]  oc_code;
	logic        retry_ok, ol_flt, ss_flt, cur_en, temp_en, volt_en, steady;
	int          err_total, comparisons;

	// ------------------------------------------------------------
	// Instances
	// ------------------------------------------------------------
	channel2_diag_sense_regs #(.RETRY_US(5)) i_channel2_diag_sense_regs (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
		.ch_on_i(ch_on), .ch_fault_i(ch_fault), .fault_shutdown_i(shut),
		.thermal_ok_i(therm_ok), .switch_state_register_wr_i(sw_wr),
		.open_load_raw_i(ol_raw), .supply_short_raw_i(ss_raw),
		.cur_conv_i(cur_conv), .temp_conv_i(temp_conv), .diag_cfg_o(cfg),
		.ch2_steady_overcurrent_code_o(oc_code),
		.steady_limit_active_o(steady), .retry_allow_o(retry_ok),
		.open_load_fault_o(ol_flt), .supply_short_fault_o(ss_flt),
		.cur_conv_en_o(cur_en), .temp_conv_en_o(temp_en),
		.volt_conv_en_o(volt_en));

	reg_host_model i_reg_host (
		.clk_i(clk_i), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
		.reg_wdata_o(wdata), .reg_rdata_i(rdata));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic check(input string n, input logic [15:0] e,
	                     input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : check

	// Read a register and compare
	task automatic rchk(input string n, input logic [7:0] a,
	                    input logic [15:0] e);
		logic [15:0] d;
		i_reg_host.rd_reg(a, d);
		`CHK(n, e, d);
	endtask : rchk

	// Write then read back
	task automatic wchk(input string n, input logic [7:0] a,
	                    input logic [15:0] w, input logic [15:0] e);
		i_reg_host.wr_reg(a, w);
		rchk(n, a, e);
	endtask : wchk

	// One-cycle pulse on a status input
	task automatic pulse(ref logic s);
		@(posedge clk_i);
		#1;
		s = 1'b1;
		@(posedge clk_i);
		#1;
		s = 1'b0;
	endtask : pulse

	// One converter result; valid lasts a single cycle
	task automatic conv(input logic t, input logic [9:0] v);
		@(posedge clk_i);
		#1;
		if (t) temp_conv = '{1'b1, v};
		else cur_conv = '{1'b1, v};
		@(posedge clk_i);
		#1;
		cur_conv  = '0;
		temp_conv = '0;
	endtask : conv

	task automatic results();
		$display("errors %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : results

	// Free-running 20 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	// Longest path is the blanking wait, so this bound is generous
	initial begin
		repeat (40000) @(posedge clk_i);
		err_total++;
		results();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		int n;
		err_total = 0;
		comparisons = 0;
		rst_b_i = 1'b0;
		{ch_on, ch_fault, shut, sw_wr, ol_raw, ss_raw} = '0;
		therm_ok = 1'b1;
		cur_conv = '0;
		temp_conv = '0;
		repeat (5) @(posedge clk_i);
		#1;
		rst_b_i = 1'b1;
		// Reset values, then an unmapped offset
		rchk("limit", 8'h17, 16'h0088);
		rchk("diag", 8'h18, 16'hC002);
		rchk("cur", 8'h19, 16'h0000);
		rchk("temp", 8'h1A, 16'h0000);
		rchk("unmapped", 8'h20, 16'h0000);
		`CHK("oc code", 16'h8, oc_code);
		`CHK("sense en", 16'h1, {volt_en, temp_en, cur_en});
		// Bits 13-0 set, sense-off bits 15-14 clear, with channel off and no fault
		wchk("diag all", 8'h18, 16'h3FFF, 16'h3FFF);
		`CHK("cfg", 16'h3FFF, cfg);
		`CHK("sense en", 16'h6, {volt_en, temp_en, cur_en});
		// Off-state checks refused while on, dropped when on later
		ch_on = 1'b1;
		wchk("chk on", 8'h18, 16'h0018, 16'h0000);
		ch_on = 1'b0;
		wchk("chk off", 8'h18, 16'h0018, 16'h0018);
		ch_on = 1'b1;
		rchk("chk armed", 8'h18, 16'h0000);
		ch_on = 1'b0;
		// Accurate open-load mode refused during a fault
		ch_fault = 1'b1;
		wchk("acc flt", 8'h18, 16'h0200, 16'h0000);
		ch_fault = 1'b0;
		wchk("acc ok", 8'h18, 16'h0200, 16'h0200);
		// Every supported threshold code
		for (n = 0; n <= 12; n++) begin
			wchk("limit", 8'h17, 16'(n), 16'(n));
			`CHK("oc code", 16'(n), oc_code);
		end
		// Results: fresh flag set, cleared by read, writes ignored
		i_reg_host.wr_reg(8'h18, 16'h0000);
		conv(1'b0, 10'h155);
		rchk("cur new", 8'h19, 16'h0555);
		wchk("cur ro", 8'h19, 16'hFFFF, 16'h0155);
		conv(1'b1, 10'h2AA);
		rchk("temp new", 8'h1A, 16'h06AA);
		wchk("temp ro", 8'h1A, 16'hFFFF, 16'h02AA);
		i_reg_host.wr_reg(8'h18, 16'h2000);
		conv(1'b0, 10'h3FF);
		rchk("cur off", 8'h19, 16'h0155);
		// Auto retry after shutdown, held until thermally recovered
		i_reg_host.wr_reg(8'h18, 16'h0000);
		therm_ok = 1'b0;
		pulse(shut);
		@(posedge clk_i);
		#1;
		`CHK("retry hold", 16'h0, retry_ok);
		repeat (150) @(posedge clk_i);
		#1;
		`CHK("retry thermal", 16'h0, retry_ok);
		therm_ok = 1'b1;
		for (n = 0; n < 1000 && retry_ok !== 1'b1; n++) begin
			@(posedge clk_i);
			#1;
		end
		`CHK("retry auto", 16'h1, retry_ok);
		// Latched off until the switch state is written
		i_reg_host.wr_reg(8'h18, 16'h0004);
		pulse(shut);
		repeat (300) @(posedge clk_i);
		#1;
		`CHK("latched", 16'h0, retry_ok);
		pulse(sw_wr);
		repeat (3) @(posedge clk_i);
		#1;
		`CHK("unlatched", 16'h1, retry_ok);
		// Longest blanking outlasts the shortest one
		i_reg_host.wr_reg(8'h18, 16'h0180);
		ol_raw = 1'b1;
		ss_raw = 1'b1;
		repeat (8100) @(posedge clk_i);
		#1;
		`CHK("blank long", 16'h0, {ol_flt, ss_flt});
		ol_raw = 1'b0;
		ss_raw = 1'b0;
		// Shortest blanking, 0.4 ms is 8000 cycles
		i_reg_host.wr_reg(8'h18, 16'h0000);
		ol_raw = 1'b1;
		ss_raw = 1'b1;
		repeat (7999) @(posedge clk_i);
		#1;
		`CHK("blank early", 16'h0, {ol_flt, ss_flt});
		repeat (1) @(posedge clk_i);
		#1;
		`CHK("blank done", 16'h3, {ol_flt, ss_flt});
		// Inrush window holds off the steady limit, code 0 skips it
		i_reg_host.wr_reg(8'h17, 16'h0108);
		ch_on = 1'b1;
		repeat (100) @(posedge clk_i);
		#1;
		`CHK("inrush", 16'h0, steady);
		`CHK("oc inrush", 16'h8, oc_code);
		ch_on = 1'b0;
		i_reg_host.wr_reg(8'h17, 16'h0008);
		ch_on = 1'b1;
		repeat (2) @(posedge clk_i);
		#1;
		`CHK("steady", 16'h1, steady);
		ch_on = 1'b0;
		// Reset in mid-run restores the defaults
		rst_b_i = 1'b0;
		repeat (5) @(posedge clk_i);
		#1;
		rst_b_i = 1'b1;
		rchk("limit rst", 8'h17, 16'h0088);
		rchk("diag rst", 8'h18, 16'hC002);
		results();
	end
endmodule : tb_channel2_diag_sense_regs
